//--- lane_model.sv
module lane_model
  import retimer_pkg::*;
#(
  parameter int TICKS = 768,
  parameter int PEAK = 4
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Boost chosen by the block.
  input wire logic [retimer_pkg::BOOST_W-1:0] boost_i,
  // Oscillator ticks, eye scores and tap errors.
  output logic vco_tick_o,
  output logic score_valid_o,
  output logic [retimer_pkg::SCORE_W-1:0] score_o,
  output logic [retimer_pkg::TAPS-1:0] dfe_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] acc_q;
  logic [3:0] gap_q;
  logic [12:0] sum;
  assign sum = acc_q + 13'(TICKS);
  // Spreads TICKS ticks over each 2048-cycle window and gives a score every 16 cycles.
  // The score climbs up to PEAK and then dips, a channel that needs no reprogramming.
  always_ff @(posedge clk_i)
  begin
    acc_q <= rst_i ? 13'h0000 : (sum >= 13'h0800 ? sum - 13'h0800 : sum);
    vco_tick_o <= !rst_i && sum >= 13'h0800;
    gap_q <= rst_i ? 4'h0 : gap_q + 4'h1;
    score_valid_o <= !rst_i && gap_q == 4'hF;
    score_o <= rst_i ? 8'h00 : (gap_q != 4'hF) ? ~score_o :
      (boost_i <= 5'(PEAK)) ? 8'(8'h0A + 8'h0A * boost_i) : 8'h14;
    dfe_err_o <= 5'($urandom);
  end
endmodule : lane_model

//--- prbs_gen.sv
module prbs_gen
  import retimer_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pattern control and output.
  prbs_if.gen p
);

  typedef struct packed {
    logic [30:0] lfsr;
    logic out;
  } pg_t;

  localparam logic [30:0] SEED = 31'h0000_0001;

  pg_t q, d;
  logic fb;

  // Advances the selected polynomial and reseeds any all-zero state.
  always_comb
  begin
    d = q;
    fb = p.poly31 ? (q.lfsr[30] ^ q.lfsr[27]) : (q.lfsr[8] ^ q.lfsr[4]);
    if (p.en)
    begin
      d.lfsr = {q.lfsr[29:0], fb};
      if (!p.poly31)
        d.lfsr[30:9] = '0;
      d.out = fb;
    end
    if (d.lfsr == '0)
      d.lfsr = SEED;
  end

  // Registers the generator state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '{lfsr: SEED, out: 1'b0};
    else
      q <= d;
  end

  assign p.bit_out = q.out;

  property p_never_zero;
    @(posedge clk_i) disable iff (rst_i) q.lfsr != '0;
  endproperty
  a_never_zero: assert property (p_never_zero) else $error("Pattern state is zero.");

  property p_prbs9_taps;
    @(posedge clk_i) disable iff (rst_i)
      (p.en && !p.poly31 && $past(p.en) && !$past(p.poly31) && $past(q.lfsr) != '0)
      |-> q.out == ($past(q.lfsr[8]) ^ $past(q.lfsr[4]));
  endproperty
  a_prbs9_taps: assert property (p_prbs9_taps) else $error("Nine-bit taps wrong.");

endmodule : prbs_gen

//--- prbs_if.sv
// Pattern generator control and serial output.
interface prbs_if;
  logic en;
  logic poly31;
  logic bit_out;
  modport gen (input en, input poly31, output bit_out);
  modport user (output en, output poly31, input bit_out);
endinterface : prbs_if

//--- retimer_ctrl.sv
// Behaviour
// - The two lanes lock, adapt, generate patterns and drive outputs independently.
// - Adaptation starts as soon as the clock recovery locks after a signal appears.
// - Any clock recovery reset restarts the adaptation of that lane.
// - Adaptation steps the boost upward and keeps the setting with the best eye score.
// - When the score fails to improve for the look-beyond depth, the best lower boost is kept.
// - Five feedback taps adapt weight and sign alongside the boost search.
// - Each lane generates a selectable nine-bit or thirty-one-bit pattern.
// - An output selector picks raw, retimed, pattern or opposite-lane data.
// - Swing, pre-emphasis, edge rate and polarity are settable; polarity inverts data.
// - Swing and pre-emphasis come only from software writes per lane.
// - Lock is judged by counting oscillator ticks over a reference-clock window.
// - The oscillator is preset to a chosen rate so lock loss is seen within one window.
// - Four-level straps decode to 0, R, Float or 1 while the mode pin is low.
// - The mode pin selects target, controller or strap control.
//
// Added by the designer: register access over Wishbone and the register addresses.
module retimer_ctrl
  import retimer_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Analog lane status.
  input wire logic [retimer_pkg::LANES-1:0] sig_detect_i,
  input wire logic [retimer_pkg::LANES-1:0] cdr_reset_i,
  input wire logic [retimer_pkg::LANES-1:0] vco_tick_i,
  input wire logic [retimer_pkg::LANES-1:0] score_valid_i,
  input wire logic [retimer_pkg::LANES-1:0][retimer_pkg::SCORE_W-1:0] score_i,
  input wire logic [retimer_pkg::LANES-1:0][retimer_pkg::TAPS-1:0] dfe_err_i,
  input wire logic [retimer_pkg::LANES-1:0] raw_data_i,
  input wire logic [retimer_pkg::LANES-1:0] retimed_data_i,
  // Analog lane controls.
  output logic [retimer_pkg::LANES-1:0] lock_o,
  output logic [retimer_pkg::LANES-1:0][retimer_pkg::BOOST_W-1:0] boost_o,
  output logic [retimer_pkg::LANES-1:0][retimer_pkg::TAPS-1:0][retimer_pkg::TAP_W-1:0] dfe_tap_o,
  output logic [retimer_pkg::LANES-1:0][2:0] vco_preset_o,
  output logic [retimer_pkg::LANES-1:0][3:0] swing_o,
  output logic [retimer_pkg::LANES-1:0][3:0] preemph_o,
  output logic [retimer_pkg::LANES-1:0] slew_limit_o,
  output logic [retimer_pkg::LANES-1:0] data_o,
  // Mode and strap pins.
  input wire logic [2:0] mode_thermo_i,
  input wire logic [retimer_pkg::STRAPS-1:0][2:0] strap_thermo_i,
  output logic [1:0] mode_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {A_IDLE, A_WAIT_LOCK, A_MEASURE, A_DONE} adapt_t;

  typedef struct packed {
    adapt_t st;
    logic [BOOST_W-1:0] boost;
    logic [BOOST_W-1:0] best_boost;
    logic [SCORE_W-1:0] best_score;
    logic [3:0] miss;
    logic [TAPS-1:0][TAP_W-1:0] tap;
    logic [11:0] ticks;
    logic lock;
    logic data;
  } lane_t;

  typedef struct packed {
    lane_t [LANES-1:0] ln;
    logic [LANES-1:0][15:0] ctrl;
    logic [3:0] depth;
    logic [EVW-1:0] stat;
    logic [EVW-1:0] mask;
    logic [11:0] win;
    logic [STRAPS-1:0][1:0] strap;
    logic [1:0] mode;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } st_t;

  localparam logic [BOOST_W-1:0] BOOST_MAX = '1;
  localparam logic [TAP_W-1:0] TAP_POS_MAX = {1'b0, {(TAP_W-1){1'b1}}};
  localparam logic [TAP_W-1:0] TAP_NEG_MAX = {1'b1, {(TAP_W-1){1'b0}}};

  st_t q, d;
  logic [LANES-1:0] pat_bit;
  level_t mode_lvl;
  level_t [STRAPS-1:0] strap_lvl;
  logic req;

  // ---------------------------------------------------------------
  // Pattern generators and strap decoders
  // ---------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    prbs_if pif ();
    assign pif.en = (q.ctrl[l][F_SEL +: 2] == SRC_PRBS);
    assign pif.poly31 = q.ctrl[l][F_P31];
    assign pat_bit[l] = pif.bit_out;
    prbs_gen u_prbs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .p(pif.gen)
    );
  end

  strap_decode u_mode (
    .thermo_i(mode_thermo_i),
    .level_o(mode_lvl)
  );

  for (genvar s = 0; s < STRAPS; s++)
  begin : g_strap
    strap_decode u_dec (
      .thermo_i(strap_thermo_i[s]),
      .level_o(strap_lvl[s])
    );
  end

  assign req = wb_cyc_i && wb_stb_i && !q.ack;

  // Merges byte lanes of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [EVW-1:0] ev;
    logic [11:0] exp_cnt;
    logic [11:0] cnt;
    logic lk;
    logic [31:0] w;
    d = q;
    ev = '0;
    exp_cnt = '0;
    cnt = '0;
    lk = 1'b0;
    w = '0;
    d.win = (q.win == WIN_LAST) ? '0 : q.win + 12'h001;
    // Mode pin and straps; straps are only captured for readback in pin mode.
    d.mode = mode_lvl;
    if (mode_lvl == LVL_0)
      d.strap = strap_lvl;
    // Each lane runs on its own inputs and registers, apart from the shared depth, the shared window counter and the opposite-lane loopback data.
    for (int l = 0; l < LANES; l++)
    begin
      // Lock check: ticks counted per reference window versus preset rate.
      cnt = q.ln[l].ticks + {11'h000, vco_tick_i[l]};
      exp_cnt = RATE_COUNT[q.ctrl[l][F_RATE +: 3]];
      d.ln[l].ticks = cnt;
      if (q.win == WIN_LAST)
      begin
        lk = (cnt + LOCK_TOL >= exp_cnt) && (cnt <= exp_cnt + LOCK_TOL);
        d.ln[l].lock = lk && sig_detect_i[l] && !cdr_reset_i[l];
        d.ln[l].ticks = '0;
      end
      if (cdr_reset_i[l] || !sig_detect_i[l])
        d.ln[l].lock = 1'b0;
      ev[l*EV_PER_LANE] = d.ln[l].lock && !q.ln[l].lock;
      ev[l*EV_PER_LANE+1] = !d.ln[l].lock && q.ln[l].lock;
      // Adaptation sequencer.
      unique case (q.ln[l].st)
        A_IDLE:
          if (sig_detect_i[l])
            d.ln[l].st = A_WAIT_LOCK;
        A_WAIT_LOCK:
          if (q.ln[l].lock)
          begin
            d.ln[l].st = A_MEASURE;
            d.ln[l].boost = '0;
            d.ln[l].best_boost = '0;
            d.ln[l].best_score = '0;
            d.ln[l].miss = '0;
          end
        A_MEASURE:
          if (score_valid_i[l])
          begin
            // Sign-sign update of the feedback taps, saturating.
            for (int t = 0; t < TAPS; t++)
            begin
              if (dfe_err_i[l][t] && q.ln[l].tap[t] != TAP_POS_MAX)
                d.ln[l].tap[t] = q.ln[l].tap[t] + 1'b1;
              else if (!dfe_err_i[l][t] && q.ln[l].tap[t] != TAP_NEG_MAX)
                d.ln[l].tap[t] = q.ln[l].tap[t] - 1'b1;
            end
            if (score_i[l] > q.ln[l].best_score)
            begin
              d.ln[l].best_score = score_i[l];
              d.ln[l].best_boost = q.ln[l].boost;
              d.ln[l].miss = '0;
            end
            else
              d.ln[l].miss = q.ln[l].miss + 4'h1;
            if (d.ln[l].miss >= q.depth || q.ln[l].boost == BOOST_MAX)
            begin
              d.ln[l].boost = d.ln[l].best_boost;
              d.ln[l].st = A_DONE;
              ev[l*EV_PER_LANE+2] = 1'b1;
            end
            else
              d.ln[l].boost = q.ln[l].boost + 1'b1;
          end
        A_DONE:
          if (!q.ln[l].lock)
            d.ln[l].st = A_WAIT_LOCK;
        default:
          d.ln[l].st = A_IDLE;
      endcase
      if (!sig_detect_i[l])
        d.ln[l].st = A_IDLE;
      else if (cdr_reset_i[l])
        d.ln[l].st = A_WAIT_LOCK;
      // Output selection and polarity.
      unique case (src_t'(q.ctrl[l][F_SEL +: 2]))
        SRC_RAW: d.ln[l].data = raw_data_i[l];
        SRC_RETIMED: d.ln[l].data = retimed_data_i[l];
        SRC_PRBS: d.ln[l].data = pat_bit[l];
        SRC_LOOP: d.ln[l].data = retimed_data_i[LANES-1-l];
      endcase
      d.ln[l].data = d.ln[l].data ^ q.ctrl[l][F_POL];
    end
    // Register bus: one-cycle acknowledge, then dropped.
    d.ack = req;
    d.dat = '0;
    if (req)
    begin
      unique case (wb_adr_i)
        OFS_CTRL0: w = {16'h0000, q.ctrl[0]};
        OFS_CTRL1: w = {16'h0000, q.ctrl[1]};
        OFS_STATUS:
          for (int l = 0; l < LANES; l++)
            w[l*8 +: 8] = {3'h0, q.ln[l].st == A_DONE, 1'b0, q.ln[l].st};
        OFS_BOOST:
          for (int l = 0; l < LANES; l++)
            w[l*8 +: 8] = {2'h0, q.ln[l].lock, q.ln[l].boost};
        OFS_IRQ_STAT: w[EVW-1:0] = q.stat;
        OFS_IRQ_MASK: w[EVW-1:0] = q.mask;
        OFS_STRAP: w = {22'h0, q.mode, q.strap};
        OFS_DEPTH: w[3:0] = q.depth;
        default: w = '0;
      endcase
      if (!wb_we_i)
        d.dat = w;
      else
        unique case (wb_adr_i)
          OFS_CTRL0: d.ctrl[0] = 16'(merge(w, wb_dat_i, wb_sel_i));
          OFS_CTRL1: d.ctrl[1] = 16'(merge(w, wb_dat_i, wb_sel_i));
          OFS_IRQ_STAT:
            if (wb_sel_i[0])
              d.stat = q.stat & ~wb_dat_i[EVW-1:0];
          OFS_IRQ_MASK: d.mask = EVW'(merge(w, wb_dat_i, wb_sel_i));
          OFS_DEPTH: d.depth = 4'(merge(w, wb_dat_i, wb_sel_i));
          default: d.dat = '0;
        endcase
    end
    // New events win over a clear in the same cycle.
    d.stat = d.stat | ev;
    d.irq = |(d.stat & d.mask);
  end

  // Registers all state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.ctrl <= {LANES{CTRL_RST}};
      q.depth <= DEPTH_RST;
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign irq_o = q.irq;
  assign mode_o = q.mode;
  for (genvar l = 0; l < LANES; l++)
  begin : g_out
    assign lock_o[l] = q.ln[l].lock;
    assign boost_o[l] = q.ln[l].boost;
    assign dfe_tap_o[l] = q.ln[l].tap;
    assign vco_preset_o[l] = q.ctrl[l][F_RATE +: 3];
    assign swing_o[l] = q.ctrl[l][F_SWING +: 4];
    assign preemph_o[l] = q.ctrl[l][F_EMPH +: 4];
    assign slew_limit_o[l] = q.ctrl[l][F_SLEW];
    assign data_o[l] = q.ln[l].data;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_cdr_restart;
    @(posedge clk_i) disable iff (rst_i)
      (cdr_reset_i[0] && sig_detect_i[0]) |=> q.ln[0].st == A_WAIT_LOCK;
  endproperty
  a_cdr_restart: assert property (p_cdr_restart) else $error("Reset did not restart.");

  property p_start_on_lock;
    @(posedge clk_i) disable iff (rst_i)
      (q.ln[1].st == A_WAIT_LOCK && q.ln[1].lock && sig_detect_i[1] && !cdr_reset_i[1])
      |=> q.ln[1].st == A_MEASURE && q.ln[1].boost == '0;
  endproperty
  a_start_on_lock: assert property (p_start_on_lock) else $error("Adaptation late.");

  property p_settle_best;
    @(posedge clk_i) disable iff (rst_i)
      (q.ln[0].st == A_MEASURE && $past(q.ln[0].st) == A_MEASURE ##1 q.ln[0].st == A_DONE)
      |-> q.ln[0].boost == q.ln[0].best_boost;
  endproperty
  a_settle_best: assert property (p_settle_best) else $error("Settled off best.");

  property p_boost_step;
    @(posedge clk_i) disable iff (rst_i)
      (q.ln[0].st == A_MEASURE && score_valid_i[0] && sig_detect_i[0] && !cdr_reset_i[0])
      ##1 (q.ln[0].st == A_MEASURE) |-> q.ln[0].boost == $past(q.ln[0].boost) + 1'b1;
  endproperty
  a_boost_step: assert property (p_boost_step) else $error("Boost not stepped.");

  property p_polarity;
    @(posedge clk_i) disable iff (rst_i)
      (q.ctrl[0][F_SEL +: 2] == SRC_RAW) |=> data_o[0] == ($past(raw_data_i[0]) ^ $past(q.ctrl[0][F_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("Polarity wrong.");

  property p_loopback;
    @(posedge clk_i) disable iff (rst_i)
      (q.ctrl[1][F_SEL +: 2] == SRC_LOOP && !q.ctrl[1][F_POL]) |=> data_o[1] == $past(retimed_data_i[0]);
  endproperty
  a_loopback: assert property (p_loopback) else $error("Loopback wrong.");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("Ack held.");

  property p_lock_drop;
    @(posedge clk_i) disable iff (rst_i) !sig_detect_i[0] |=> !lock_o[0] && q.ln[0].st == A_IDLE;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("Lock held without signal.");

  property p_independent;
    @(posedge clk_i) disable iff (rst_i)
      (cdr_reset_i[0] && !cdr_reset_i[1] && sig_detect_i[1] && q.ln[1].st == A_DONE && q.ln[1].lock)
      |=> q.ln[1].st == A_DONE;
  endproperty
  a_independent: assert property (p_independent) else $error("Lane crosstalk.");

endmodule : retimer_ctrl

//--- retimer_ctrl_bench.sv
module retimer_ctrl_bench
  import retimer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_o;
  logic [LANES-1:0] sig_detect_i = '0, cdr_reset_i = '0, raw_data_i = '0, retimed_data_i = '0;
  wire [LANES-1:0] vco_tick_i, score_valid_i;
  wire [LANES-1:0][SCORE_W-1:0] score_i;
  wire [LANES-1:0][TAPS-1:0] dfe_err_i;
  logic [LANES-1:0] lock_o, slew_limit_o, data_o;
  logic [LANES-1:0][BOOST_W-1:0] boost_o;
  logic [LANES-1:0][TAPS-1:0][TAP_W-1:0] dfe_tap_o;
  logic [LANES-1:0][2:0] vco_preset_o;
  logic [LANES-1:0][3:0] swing_o, preemph_o;
  logic [2:0] mode_thermo_i = 3'h0;
  logic [STRAPS-1:0][2:0] strap_thermo_i = '0;
  logic [1:0] mode_o;
  int failures = 0;
  int total_checks = 0;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [79:0] s;
  logic [1:0] e, r, t;
  logic [15:0] v;
  logic oka, okb, ones;
  int n, l1, la, lb;
  // Source selections tried in turn: raw, inverted raw, retimed, loopback.
  localparam logic [3:0][3:0] SRC_CODES = {4'h3, 4'h1, 4'h4, 4'h0};

  retimer_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sig_detect_i(sig_detect_i),
    .cdr_reset_i(cdr_reset_i), .vco_tick_i(vco_tick_i), .score_valid_i(score_valid_i),
    .score_i(score_i), .dfe_err_i(dfe_err_i), .raw_data_i(raw_data_i),
    .retimed_data_i(retimed_data_i), .lock_o(lock_o), .boost_o(boost_o),
    .dfe_tap_o(dfe_tap_o), .vco_preset_o(vco_preset_o), .swing_o(swing_o),
    .preemph_o(preemph_o), .slew_limit_o(slew_limit_o), .data_o(data_o),
    .mode_thermo_i(mode_thermo_i), .strap_thermo_i(strap_thermo_i), .mode_o(mode_o));

  // One analog lane model per lane, ticking at the rate of preset zero.
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    lane_model #(.TICKS(int'(RATE_COUNT[0])), .PEAK(4)) i_model (.clk_i(clk_i),
      .rst_i(rst_i), .boost_i(boost_o[l]), .vco_tick_o(vco_tick_i[l]),
      .score_valid_o(score_valid_i[l]), .score_o(score_i[l]), .dfe_err_o(dfe_err_i[l]));
  end

  // The clock toggles every half period of 10 ns.
  always #10 clk_i = ~clk_i;

  // ----
  // Checking tasks
  // ----
  task check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // One classic Wishbone cycle; the note says whether the read data is compared.
  task bus(input logic we, input logic [4:0] adr, input logic [31:0] dat, input logic chk);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    exp_q.push_back({chk & !we, dat});
    // Waits as long as the slave takes; only the watchdog ends a hang.
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task wait_lock();
    n = 0;
    while (lock_o[0] !== 1'b1 && n < 7000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_lock

  // Waits for lock and adaptation, then checks results and clears the events.
  task adapt(input logic [31:0] stat);
    wait_lock();
    check(lock_o[0] === 1'b1, "no lock");
    repeat (4) @(posedge clk_i);
    check(irq_o === 1'b0, "masked event raised irq");
    n = 0;
    while (irq_o !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    check(irq_o === 1'b1, "no adaptation done irq");
    check(boost_o[0] === 5'h04, "settled boost");
    check(boost_o[1] === 5'h00, "idle lane moved");
    bus(1'b0, OFS_STATUS, 32'h0000_0013, 1'b1);
    bus(1'b0, OFS_BOOST, 32'h0000_0024, 1'b1);
    bus(1'b0, OFS_IRQ_STAT, stat, 1'b1);
    bus(1'b1, OFS_IRQ_STAT, stat, 1'b0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0, 1'b1);
    check(irq_o === 1'b0, "irq not cleared");
  endtask : adapt

  // Compares each acknowledged read with the oldest note.
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1)
    begin
      note = exp_q.pop_front();
      if (note[32])
        check(wb_dat_o === note[31:0], "read data");
    end
  end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(32'hB4456255));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_CTRL0, 32'(CTRL_RST), 1'b1);
    bus(1'b0, OFS_CTRL1, 32'(CTRL_RST), 1'b1);
    bus(1'b0, OFS_DEPTH, 32'(DEPTH_RST), 1'b1);
    bus(1'b0, OFS_IRQ_MASK, 32'h0, 1'b1);
    check(lock_o === 2'h0 && irq_o === 1'b0, "reset outputs");
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      strap_thermo_i <= {STRAPS{3'((1 << k) - 1)}};
      repeat (3) @(posedge clk_i);
      bus(1'b0, OFS_STRAP, 32'(8'h55 * k), 1'b1);
    end
    for (int m = 0; m < 4; m++)
    begin
      mode_thermo_i <= 3'((1 << m) - 1);
      repeat (3) @(posedge clk_i);
      check(mode_o === 2'(m), "mode decode");
    end
    strap_thermo_i <= '0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, OFS_STRAP, 32'h0000_03FF, 1'b1);
    $display("test straps done");
    for (int j = 0; j < 4; j++)
    begin
      v = 16'(SRC_CODES[j]);
      bus(1'b1, OFS_CTRL0, 32'(v), 1'b0);
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 40; i++)
      begin
        @(posedge clk_i);
        if (i > 1)
          check(data_o[0] === e[1], "output source");
        e[1] = e[0];
        r = 2'($urandom);
        t = 2'($urandom);
        raw_data_i <= r;
        retimed_data_i <= t;
        e[0] = (v[1:0] == 2'h0 ? r[0] : v[1:0] == 2'h3 ? t[1] : t[0]) ^ v[2];
      end
    end
    $display("test source done");
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b1, OFS_CTRL0, p ? 32'h0000_000A : 32'h0000_0002, 1'b0);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 80; i++)
      begin
        @(posedge clk_i);
        s[i] = data_o[0];
      end
      l1 = p ? 31 : 9;
      la = p ? 3 : 4;
      lb = p ? 28 : 5;
      oka = 1'b1;
      okb = 1'b1;
      ones = 1'b0;
      for (int i = l1; i < 80; i++)
      begin
        oka &= (s[i] === (s[i - la] ^ s[i - l1]));
        okb &= (s[i] === (s[i - lb] ^ s[i - l1]));
        ones |= s[i];
      end
      check(oka | okb, "pattern recurrence");
      check(ones, "pattern stuck at zero");
    end
    $display("test pattern done");
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0004, 1'b0);
    sig_detect_i[0] <= 1'b1;
    adapt(32'h0000_0005);
    cdr_reset_i[0] <= 1'b1;
    @(posedge clk_i);
    cdr_reset_i[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(lock_o[0] === 1'b0, "lock kept in recovery reset");
    adapt(32'h0000_0007);
    // The second lane locks and adapts on its own, then survives a recovery reset of lane 0.
    sig_detect_i[1] <= 1'b1;
    repeat (2400) @(posedge clk_i);
    cdr_reset_i[0] <= 1'b1;
    @(posedge clk_i);
    cdr_reset_i[0] <= 1'b0;
    check(boost_o[1] === 5'h04 && lock_o[1] === 1'b1, "second lane adaptation");
    bus(1'b0, OFS_STATUS, 32'h0000_1301, 1'b1);
    $display("test adaptation done");
    v = 16'($urandom);
    bus(1'b1, OFS_CTRL1, {16'h0, v}, 1'b0);
    repeat (2) @(posedge clk_i);
    check(swing_o[1] === v[7:4] && preemph_o[1] === v[11:8], "drive levels");
    check(slew_limit_o[1] === v[12] && vco_preset_o[1] === v[15:13], "edge and rate");
    check(swing_o[0] === 4'h0, "other lane drive moved");
    bus(1'b0, OFS_CTRL1, {16'h0, v}, 1'b1);
    $display("test driver done");
    report_and_stop();
  end
endmodule : retimer_ctrl_bench

//--- retimer_pkg.sv
package retimer_pkg;

  // ---------------------------------------------------------------
  // Geometry and timing
  // ---------------------------------------------------------------
  localparam int LANES = 2;
  localparam int BOOST_W = 5;
  localparam int SCORE_W = 8;
  localparam int TAPS = 5;
  localparam int TAP_W = 6;
  localparam int STRAPS = 4;
  localparam int CLK_HZ = 50_000_000;
  localparam int REF_HZ = 25_000_000;
  localparam int LOCK_WINDOW_REF = 1024;
  localparam int WIN_CLKS = LOCK_WINDOW_REF * (CLK_HZ / REF_HZ);
  localparam logic [11:0] WIN_LAST = 12'(WIN_CLKS - 1);
  localparam logic [11:0] LOCK_TOL = 12'h002;
  localparam logic [3:0] DEPTH_RST = 4'h3;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_BOOST = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFS_STRAP = 5'h18;
  localparam logic [4:0] OFS_DEPTH = 5'h1C;

  // Lane control word fields.
  localparam int F_SEL = 0;
  localparam int F_POL = 2;
  localparam int F_P31 = 3;
  localparam int F_SWING = 4;
  localparam int F_EMPH = 8;
  localparam int F_SLEW = 12;
  localparam int F_RATE = 13;
  localparam logic [15:0] CTRL_RST = 16'h0001;

  // Interrupt status bits per lane: lock gained, lock lost, adaptation done.
  localparam int EV_PER_LANE = 3;
  localparam int EVW = LANES * EV_PER_LANE;

  // Expected reference-window tick counts for each preset rate.
  localparam logic [7:0][11:0] RATE_COUNT = {12'h5A0, 12'h540, 12'h4E0, 12'h480,
                                             12'h420, 12'h3C0, 12'h360, 12'h300};

  // Four-level strap codes.
  typedef enum logic [1:0] {LVL_0, LVL_R, LVL_FLOAT, LVL_1} level_t;
  // Output source choices.
  typedef enum logic [1:0] {SRC_RAW, SRC_RETIMED, SRC_PRBS, SRC_LOOP} src_t;
  // Control modes.
  typedef enum logic [1:0] {MODE_PIN, MODE_NA, MODE_CONTROLLER, MODE_TARGET} mode_t;

endpackage : retimer_pkg

//--- strap_decode.sv
module strap_decode
  import retimer_pkg::*;
(
  // Comparator thermometer outputs: above 0.2, above 0.5, above 0.83 of supply.
  input wire logic [2:0] thermo_i,
  // Decoded level.
  output level_t level_o
);

  // Maps the three thresholds to the four strap levels.
  always_comb
  begin
    if (thermo_i[2])
      level_o = LVL_1;
    else if (thermo_i[1])
      level_o = LVL_FLOAT;
    else if (thermo_i[0])
      level_o = LVL_R;
    else
      level_o = LVL_0;
  end

endmodule : strap_decode
